/* File: verilog/sss_supervisor.sv */
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
module sss_supervisor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire sss_pkg::sss_word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire sss_pkg::sss_word_t hwdata,
  input wire logic hready,
  output sss_pkg::sss_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire sss_pkg::sss_word_t user_config_word_zero,
  input wire logic write_protect_unlocked,
  input wire logic brownout_detect_out,
  input wire logic por_trip_in,
  input wire logic [5:0] other_reset_src,
  output sss_pkg::sss_vsel_t brownout_threshold_select,
  output sss_pkg::sss_level_t brownout_level_cv,
  output logic brownout_detector_enable,
  output logic brownout_reset_select,
  output logic brownout_chip_reset_req,
  output logic brownout_irq_req,
  output logic temp_sensor_enable,
  output logic temp_sensor_adc_select,
  output logic por_circuit_enable,
  output logic por_chip_reset_req
);
  import sss_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic addr_ok;
  sss_offs_t addr_offs;
  logic wr_pend_r;
  sss_offs_t wr_offs_r;
  sss_word_t hrdata_r;
  sss_word_t rd_word;
  logic cfg_done_r;
  logic bod_en_r;
  logic bod_en_nxt;
  sss_vsel_t vsel_r;
  sss_vsel_t vsel_nxt;
  logic rst_sel_r;
  logic rst_sel_nxt;
  logic temp_en_r;
  logic temp_en_nxt;
  sss_key_t key_r;
  sss_key_t key_nxt;
  logic prot_wr_ok;
  logic wr_bod;
  logic wr_ivs;
  logic wr_por;
  logic detect_s;
  logic por_trip_s;
  logic [NUM_OTHER_RESETS-1:0] other_rst_s;
  logic other_rst_any;
  logic por_on_nxt;
  logic por_on_r;
  sss_level_t level_r;
  sss_level_t level_nxt;
  logic bod_rst_r;
  logic bod_irq_r;
  logic por_rst_r;
  logic temp_sel_r;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // detector and trip come from the analog side, reset causes from
  // other domains; everything passes two flops before use
  sss_sync #(
    .WIDTH(2 + NUM_OTHER_RESETS)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({brownout_detect_out, por_trip_in, other_reset_src}),
    .sync_out({detect_s, por_trip_s, other_rst_s})
  );

  assign other_rst_any = |other_rst_s;

  // ----------------------------------------------------------------
  // ahb-lite address phase
  // ----------------------------------------------------------------
  // zero wait states: every transfer completes in its first data cycle
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_r;

  // only the low address byte picks a register, so the map aliases
  // through the rest of the window
  assign addr_offs = haddr[$bits(sss_offs_t)-1:0];

  // remember a write until its data phase brings hwdata
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_offs_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok && hwrite) begin
        wr_offs_r <= addr_offs;
      end
    end
  end

  // write strobes in the data phase; hsize is not checked since only
  // whole-word transfers reach this block
  always_comb begin
    wr_bod = 1'b0;
    wr_ivs = 1'b0;
    wr_por = 1'b0;
    if (!wr_pend_r) begin
      wr_bod = 1'b0;
    end else if (wr_offs_r == OFFS_BROWNOUT_CTRL) begin
      wr_bod = 1'b1;
    end else if (wr_offs_r == OFFS_IVS_CTRL) begin
      wr_ivs = 1'b1;
    end else if (wr_offs_r == OFFS_POR_CTRL) begin
      wr_por = 1'b1;
    end
  end

  // protected fields only take bus writes while the lock logic says unlocked
  assign prot_wr_ok = write_protect_unlocked;

  // ----------------------------------------------------------------
  // next values of the control fields
  // ----------------------------------------------------------------
  // config defaults land on the first edge after reset release, so a
  // strap-like value is never caught by the asynchronous reset itself
  always_comb begin
    bod_en_nxt = bod_en_r;
    vsel_nxt = vsel_r;
    rst_sel_nxt = rst_sel_r;
    if (!cfg_done_r) begin
      bod_en_nxt = user_config_word_zero[CFG_BIT_BOD_ENABLE];
      vsel_nxt = user_config_word_zero[CFG_BIT_VSEL_HI:CFG_BIT_VSEL_LO];
      rst_sel_nxt = user_config_word_zero[CFG_BIT_RST_SEL];
    end else if (wr_bod && prot_wr_ok) begin
      bod_en_nxt = hwdata[BIT_BOD_ENABLE];
      vsel_nxt = hwdata[BIT_BOD_VSEL_HI:BIT_BOD_VSEL_LO];
      rst_sel_nxt = hwdata[BIT_BOD_RST_SEL];
    end
  end

  // sensor enable is not protected
  always_comb begin
    temp_en_nxt = temp_en_r;
    if (wr_ivs) begin
      temp_en_nxt = hwdata[BIT_TEMP_ENABLE];
    end
  end

  // key field: another reset cause wins over a write in the same cycle
  always_comb begin
    key_nxt = key_r;
    if (other_rst_any) begin
      key_nxt = KEY_RESET;
    end else if (wr_por && prot_wr_ok) begin
      key_nxt = hwdata[BIT_KEY_HI:BIT_KEY_LO];
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // configuration load flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_done_r <= 1'b0;
    end else begin
      cfg_done_r <= 1'b1;
    end
  end

  // brown-out control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bod_en_r <= 1'b0;
      vsel_r <= VSEL_RESET;
      rst_sel_r <= 1'b0;
    end else begin
      bod_en_r <= bod_en_nxt;
      vsel_r <= vsel_nxt;
      rst_sel_r <= rst_sel_nxt;
    end
  end

  // temperature sensor enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_en_r <= RESET_WORD[BIT_TEMP_ENABLE];
    end else begin
      temp_en_r <= temp_en_nxt;
    end
  end

  // power-on-reset disable key
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_r <= KEY_RESET;
    end else begin
      key_r <= key_nxt;
    end
  end

  // ----------------------------------------------------------------
  // threshold decode
  // ----------------------------------------------------------------
  // level is only informative; the analog side works from the code
  always_comb begin
    case (vsel_r)
      VSEL_2V0: level_nxt = LEVEL_2V0;
      VSEL_2V2: level_nxt = LEVEL_2V2;
      VSEL_2V4: level_nxt = LEVEL_2V4;
      VSEL_2V7: level_nxt = LEVEL_2V7;
      VSEL_3V0: level_nxt = LEVEL_3V0;
      VSEL_3V7: level_nxt = LEVEL_3V7;
      VSEL_4V0: level_nxt = LEVEL_4V0;
      VSEL_4V3: level_nxt = LEVEL_4V3;
      default: level_nxt = LEVEL_2V0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_r <= LEVEL_2V0;
    end else begin
      level_r <= level_nxt;
    end
  end

  // ----------------------------------------------------------------
  // supervisor actions
  // ----------------------------------------------------------------
  // circuit stays armed unless the exact key is held; the flag takes
  // the key's next value so it moves on the same edge as the key and
  // the output still leaves from a flop
  assign por_on_nxt = (key_nxt != POR_DISABLE_KEY);

  // armed flag, reset to match the cleared key
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_on_r <= (KEY_RESET != POR_DISABLE_KEY);
    end else begin
      por_on_r <= por_on_nxt;
    end
  end

  // reset and interrupt requests are registered to keep glitches off
  // the chip reset tree; a disabled detector can raise neither
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bod_rst_r <= 1'b0;
      bod_irq_r <= 1'b0;
    end else begin
      bod_rst_r <= bod_en_r && rst_sel_r && detect_s;
      bod_irq_r <= bod_en_r && !rst_sel_r && detect_s;
    end
  end

  // power-on trip reaches the reset tree only while the circuit is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_rst_r <= 1'b0;
    end else begin
      por_rst_r <= por_on_r && por_trip_s;
    end
  end

  // converter input follows the sensor enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_sel_r <= 1'b0;
    end else begin
      temp_sel_r <= temp_en_r;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // uses next values so a read right behind a write sees the new data
  always_comb begin
    rd_word = RESET_WORD;
    if (addr_offs == OFFS_BROWNOUT_CTRL) begin
      rd_word[BIT_BOD_ENABLE] = bod_en_nxt;
      rd_word[BIT_BOD_VSEL_HI:BIT_BOD_VSEL_LO] = vsel_nxt;
      rd_word[BIT_BOD_RST_SEL] = rst_sel_nxt;
    end else if (addr_offs == OFFS_IVS_CTRL) begin
      rd_word[BIT_TEMP_ENABLE] = temp_en_nxt;
    end else if (addr_offs == OFFS_POR_CTRL) begin
      rd_word[BIT_KEY_HI:BIT_KEY_LO] = key_nxt;
    end else if (addr_offs == OFFS_SUPPLY_STATUS) begin
      rd_word[BIT_STAT_DETECT] = detect_s;
      rd_word[BIT_STAT_POR_ON] = por_on_r;
      rd_word[BIT_STAT_CFG_DONE] = cfg_done_r;
      rd_word[BIT_STAT_BOD_RST] = bod_rst_r;
    end
  end

  // unmapped addresses read zero with an okay response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= RESET_WORD;
    end else if (addr_ok && !hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign brownout_threshold_select = vsel_r;
  assign brownout_level_cv = level_r;
  assign brownout_detector_enable = bod_en_r;
  assign brownout_reset_select = rst_sel_r;
  assign brownout_chip_reset_req = bod_rst_r;
  assign brownout_irq_req = bod_irq_r;
  assign temp_sensor_enable = temp_en_r;
  assign temp_sensor_adc_select = temp_sel_r;
  assign por_circuit_enable = por_on_r;
  assign por_chip_reset_req = por_rst_r;

endmodule

/* File: verilog/sss_pkg.sv */
package sss_pkg;

  // ----------------------------------------------------------------
  // bus types
  // ----------------------------------------------------------------
  typedef logic [31:0] sss_word_t;
  typedef logic [7:0] sss_offs_t;
  typedef logic [2:0] sss_vsel_t;
  typedef logic [8:0] sss_level_t;
  typedef logic [15:0] sss_key_t;

  // ----------------------------------------------------------------
  // register byte offsets (low address byte only)
  // ----------------------------------------------------------------
  localparam sss_offs_t OFFS_BROWNOUT_CTRL = 8'h40;
  localparam sss_offs_t OFFS_IVS_CTRL = 8'h1c;
  localparam sss_offs_t OFFS_POR_CTRL = 8'h24;
  localparam sss_offs_t OFFS_SUPPLY_STATUS = 8'h44;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_BOD_ENABLE = 0;
  localparam int BIT_BOD_VSEL_LO = 1;
  localparam int BIT_BOD_VSEL_HI = 3;
  localparam int BIT_BOD_RST_SEL = 4;
  localparam int BIT_TEMP_ENABLE = 0;
  localparam int BIT_KEY_LO = 0;
  localparam int BIT_KEY_HI = 15;
  localparam int BIT_STAT_DETECT = 0;
  localparam int BIT_STAT_POR_ON = 1;
  localparam int BIT_STAT_CFG_DONE = 2;
  localparam int BIT_STAT_BOD_RST = 3;

  // configuration word positions for the brown-out defaults
  localparam int CFG_BIT_BOD_ENABLE = 12;
  localparam int CFG_BIT_VSEL_LO = 13;
  localparam int CFG_BIT_VSEL_HI = 15;
  localparam int CFG_BIT_RST_SEL = 11;

  // ----------------------------------------------------------------
  // reset values and keys
  // ----------------------------------------------------------------
  localparam sss_word_t RESET_WORD = 32'h0000_0000;
  localparam sss_key_t POR_DISABLE_KEY = 16'h5aa5;
  localparam sss_key_t KEY_RESET = 16'h0000;
  localparam sss_vsel_t VSEL_RESET = 3'h0;
  localparam int NUM_OTHER_RESETS = 6;

  // ----------------------------------------------------------------
  // threshold codes and their levels in hundredths of a volt
  // ----------------------------------------------------------------
  localparam sss_vsel_t VSEL_2V0 = 3'h0;
  localparam sss_vsel_t VSEL_2V2 = 3'h1;
  localparam sss_vsel_t VSEL_2V4 = 3'h2;
  localparam sss_vsel_t VSEL_2V7 = 3'h3;
  localparam sss_vsel_t VSEL_3V0 = 3'h4;
  localparam sss_vsel_t VSEL_3V7 = 3'h5;
  localparam sss_vsel_t VSEL_4V0 = 3'h6;
  localparam sss_vsel_t VSEL_4V3 = 3'h7;
  localparam sss_level_t LEVEL_2V0 = 9'h0c8;
  localparam sss_level_t LEVEL_2V2 = 9'h0dc;
  localparam sss_level_t LEVEL_2V4 = 9'h0f0;
  localparam sss_level_t LEVEL_2V7 = 9'h10e;
  localparam sss_level_t LEVEL_3V0 = 9'h12c;
  localparam sss_level_t LEVEL_3V7 = 9'h172;
  localparam sss_level_t LEVEL_4V0 = 9'h190;
  localparam sss_level_t LEVEL_4V3 = 9'h1ae;

  // ----------------------------------------------------------------
  // ahb encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

endpackage

/* File: verilog/sss_sync.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// two-stage level synchroniser, one per bit
// ------------------------------------------------------------------
module sss_sync #(
  parameter int WIDTH = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

/* File: sim/sss_supervisor_props.sv */
`timescale 1ns/100ps
// --------
// port checker for the supervisor
// --------
module sss_supervisor_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire sss_pkg::sss_word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire sss_pkg::sss_word_t hwdata,
  input wire logic hready,
  input wire sss_pkg::sss_word_t user_config_word_zero,
  input wire logic write_protect_unlocked,
  input wire logic brownout_detect_out,
  input wire logic por_trip_in,
  input wire logic [5:0] other_reset_src,
  input wire sss_pkg::sss_vsel_t brownout_threshold_select,
  input wire sss_pkg::sss_level_t brownout_level_cv,
  input wire logic brownout_detector_enable,
  input wire logic brownout_reset_select,
  input wire logic brownout_chip_reset_req,
  input wire logic brownout_irq_req,
  input wire logic temp_sensor_enable,
  input wire logic temp_sensor_adc_select,
  input wire logic por_circuit_enable,
  input wire logic por_chip_reset_req
);
  import sss_pkg::*;
  logic wr_dp_r;
  sss_offs_t adr_dp_r;
  logic [2:0] up_r;
  logic [2:0] ors_r;
  logic quiet;
  logic key_wr;

  // write data phase, tracked from the taken address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_r <= 1'b0;
      adr_dp_r <= 8'h00;
    end else begin
      wr_dp_r <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
      adr_dp_r <= haddr[7:0];
    end
  end

  // edges since reset; the syncs hold stale bits before four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h4) begin
      up_r <= up_r + 3'h1;
    end
  end

  // recent reset causes, so a key write is judged only when none races it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ors_r <= 3'h0;
    end else begin
      ors_r <= {ors_r[1:0], |other_reset_src};
    end
  end

  // unlocked key field write with no reset cause nearby
  assign quiet = !(|ors_r) && !(|other_reset_src);
  assign key_wr = wr_dp_r && adr_dp_r == OFFS_POR_CTRL && write_protect_unlocked && quiet;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_level_code_map: assert property (
    brownout_threshold_select[2:1] == 2'b11 |=> brownout_level_cv ==
    ($past(brownout_threshold_select[0]) ? LEVEL_4V3 : LEVEL_4V0)) else $error("level map");
  a_locked_bod_hold: assert property (
    wr_dp_r && adr_dp_r == OFFS_BROWNOUT_CTRL && !write_protect_unlocked |=>
    $stable(brownout_detector_enable) && $stable(brownout_threshold_select))
    else $error("locked write took effect");
  a_cfg_enable_load: assert property (
    $rose(hresetn) |=> brownout_detector_enable == $past(user_config_word_zero[12]))
    else $error("enable default");
  a_bod_reset_req: assert property (
    up_r == 3'h4 |-> brownout_chip_reset_req == ($past(brownout_detector_enable) &&
    $past(brownout_reset_select) && $past(brownout_detect_out, 3))) else $error("bod reset");
  a_bod_irq_req: assert property (
    up_r == 3'h4 |-> brownout_irq_req == ($past(brownout_detector_enable) &&
    !$past(brownout_reset_select) && $past(brownout_detect_out, 3))) else $error("bod irq");
  a_key_disables_por: assert property (
    key_wr && hwdata[15:0] == POR_DISABLE_KEY |=> !por_circuit_enable) else $error("key off");
  a_other_rearms_por: assert property (
    key_wr && hwdata[15:0] != POR_DISABLE_KEY |=> por_circuit_enable) else $error("key on");
  a_reset_rearm: assert property (
    |other_reset_src |-> ##[1:4] por_circuit_enable) else $error("rearm");
  a_por_trip_req: assert property (
    up_r == 3'h4 |-> por_chip_reset_req == ($past(por_circuit_enable) &&
    $past(por_trip_in, 3))) else $error("por req");
  a_temp_adc_route: assert property (
    up_r != 3'h0 |-> temp_sensor_adc_select == $past(temp_sensor_enable)) else $error("adc");
endmodule

/* File: sim/supply_supervisor_controls_tb.sv */
`timescale 1ns/100ps
// --------
// bench top
// --------
module supply_supervisor_controls_tb;
  import sss_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  sss_word_t haddr, hwdata, hrdata, user_config_word_zero, rd;
  logic write_protect_unlocked, brownout_detect_out, por_trip_in;
  logic [5:0] other_reset_src;
  sss_vsel_t brownout_threshold_select;
  sss_level_t brownout_level_cv;
  logic brownout_detector_enable, brownout_reset_select, brownout_chip_reset_req;
  logic brownout_irq_req, temp_sensor_enable, temp_sensor_adc_select;
  logic por_circuit_enable, por_chip_reset_req;
  int errors;
  int n_checks;

  // single slave, so its ready is the bus ready
  sss_supervisor uut (.*, .hready(hreadyout), .hsize(3'h2));

  // 20 MHz bus clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input sss_word_t got, input sss_word_t exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one edge with ready high; a stuck bus ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t bus wait ran out", $time);
      summarize();
    end
  endtask

  // single word transfer; unlock held through the data phase
  task automatic xfer(input logic w, input logic u, input sss_word_t a, input sss_word_t d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    write_protect_unlocked <= u;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rdc(input sss_word_t a, input sss_word_t e, input string s);
    xfer(1'b0, 1'b0, a, 32'h0000_0000);
    chk(rd, e, s);
  endtask

  // let outputs settle past the launching edges
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic t_reset(input sss_word_t c);
    @(posedge hclk);
    hresetn <= 1'b0;
    user_config_word_zero <= c;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
    chk(brownout_detector_enable, c[12], "bod default");
    chk(brownout_threshold_select, c[15:13], "code default");
    chk(brownout_reset_select, c[11], "mode default");
    chk(por_circuit_enable, 1'b1, "por armed");
    chk(temp_sensor_enable, 1'b0, "temp off");
    rdc(OFFS_IVS_CTRL, 32'h0000_0000, "ivs reset");
    $display("reset test done");
  endtask

  // upper threshold codes, unlocked
  task automatic t_thresh;
    sss_word_t d;
    for (int c = 6; c < 8; c++) begin
      d = {27'h0, 1'b0, c[2:0], 1'b1};
      xfer(1'b1, 1'b1, OFFS_BROWNOUT_CTRL, d);
      tick(2);
      chk(brownout_threshold_select, c[2:0], "code");
      chk(brownout_level_cv, c[0] ? LEVEL_4V3 : LEVEL_4V0, "level");
      rdc(OFFS_BROWNOUT_CTRL, d, "bod readback");
    end
    $display("threshold test done");
  endtask

  // locked writes bounce; key on, key off; unmapped place
  task automatic t_protect;
    xfer(1'b1, 1'b0, OFFS_BROWNOUT_CTRL, 32'h0000_0004);
    tick(2);
    chk(brownout_threshold_select, 3'h7, "locked code");
    chk(brownout_detector_enable, 1'b1, "locked en");
    xfer(1'b1, 1'b0, OFFS_POR_CTRL, {16'h0, POR_DISABLE_KEY});
    tick(2);
    chk(por_circuit_enable, 1'b1, "locked key");
    chk(hresp, HRESP_OKAY, "locked resp");
    xfer(1'b1, 1'b1, OFFS_POR_CTRL, {16'h0, POR_DISABLE_KEY});
    tick(2);
    chk(por_circuit_enable, 1'b0, "key off");
    rdc(OFFS_POR_CTRL, {16'h0, POR_DISABLE_KEY}, "key readback");
    xfer(1'b1, 1'b1, OFFS_POR_CTRL, 32'h0000_5aa4);
    tick(2);
    chk(por_circuit_enable, 1'b1, "near key");
    xfer(1'b1, 1'b1, 32'h0000_0080, 32'hffff_ffff);
    rdc(32'h0000_0080, 32'h0000_0000, "unmapped");
    $display("protect test done");
  endtask

  task automatic t_temp;
    xfer(1'b1, 1'b0, OFFS_IVS_CTRL, 32'h0000_0001);
    tick(2);
    chk(temp_sensor_enable, 1'b1, "temp on");
    chk(temp_sensor_adc_select, 1'b1, "adc route");
    rdc(OFFS_IVS_CTRL, 32'h0000_0001, "ivs readback");
    xfer(1'b1, 1'b0, OFFS_IVS_CTRL, 32'h0000_0000);
    tick(2);
    chk(temp_sensor_adc_select, 1'b0, "adc off");
    $display("temp test done");
  endtask

  // detector below threshold in reset mode, then interrupt mode, then off
  task automatic t_bod;
    xfer(1'b1, 1'b1, OFFS_BROWNOUT_CTRL, 32'h0000_001f);
    @(posedge hclk);
    brownout_detect_out <= 1'b1;
    tick(4);
    chk(brownout_chip_reset_req, 1'b1, "reset mode");
    chk(brownout_irq_req, 1'b0, "no irq");
    rdc(OFFS_SUPPLY_STATUS, 32'h0000_000f, "status");
    xfer(1'b1, 1'b1, OFFS_BROWNOUT_CTRL, 32'h0000_000f);
    tick(2);
    chk(brownout_chip_reset_req, 1'b0, "irq mode rst");
    chk(brownout_irq_req, 1'b1, "irq mode");
    xfer(1'b1, 1'b1, OFFS_BROWNOUT_CTRL, 32'h0000_000e);
    tick(2);
    chk(brownout_irq_req, 1'b0, "bod off");
    chk(brownout_detector_enable, 1'b0, "en low");
    @(posedge hclk);
    brownout_detect_out <= 1'b0;
    $display("brown-out test done");
  endtask

  // every other reset cause re-arms the circuit
  task automatic t_por;
    @(posedge hclk);
    por_trip_in <= 1'b1;
    tick(4);
    chk(por_chip_reset_req, 1'b1, "trip");
    for (int i = 0; i < NUM_OTHER_RESETS; i++) begin
      xfer(1'b1, 1'b1, OFFS_POR_CTRL, {16'h0, POR_DISABLE_KEY});
      tick(2);
      chk(por_chip_reset_req, 1'b0, "trip masked");
      @(posedge hclk);
      other_reset_src <= 6'h1 << i;
      @(posedge hclk);
      other_reset_src <= 6'h0;
      tick(4);
      chk(por_circuit_enable, 1'b1, "rearmed");
      chk(por_chip_reset_req, 1'b1, "trip again");
    end
    @(posedge hclk);
    por_trip_in <= 1'b0;
    $display("por test done");
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    user_config_word_zero = 32'h0000_0000;
    write_protect_unlocked = 1'b0;
    brownout_detect_out = 1'b0;
    por_trip_in = 1'b0;
    other_reset_src = 6'h0;
    errors = 0;
    n_checks = 0;
    t_reset(32'h0000_d000);
    t_thresh();
    t_protect();
    t_temp();
    t_bod();
    t_por();
    t_reset(32'h0000_e800);
    summarize();
  end
endmodule

bind sss_supervisor sss_supervisor_props u_props (.*);
